// ### core/ais_top.sv
// Analog input scaling: offset, multiply and divide per channel, with object dictionary access.
// Contract
// - Present each channel's scaled value continuously, read-only.
// - Add signed offset to raw reading first.
// - Multiply corrected reading by channel numerator.
// - Divide the product by channel denominator.
// - Defaults give raw converter digits unchanged.
// - Voltage count maps to count times 10V/1023.
// - Current count maps to count times 20mA/1023.
// - Signed 16-bit offset per channel, reset zero.
// - Signed 16-bit multiplier per channel, reset one.
// - Signed 16-bit divisor per channel, reset one.
// - Subindex zero reads entry count two, read-only.
// - Values signed 32-bit; second channel optional.
// - Settings retainable; live values never saved.
`timescale 1ns/1ps
`default_nettype none
module ais_top import ais_pkg::*; #(
  parameter int ADC_W = 10,
  parameter bit HAS_CH2 = 1'b1
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Converter readings.
  input wire logic raw_valid_ch1_in,
  input wire logic [ADC_W-1:0] raw_ch1_in,
  input wire logic raw_valid_ch2_in,
  input wire logic [ADC_W-1:0] raw_ch2_in,
  // Object dictionary access.
  input wire logic od_req_in,
  input wire logic od_write_in,
  input wire logic [15:0] od_index_in,
  input wire logic [7:0] od_subidx_in,
  input wire logic [31:0] od_wdata_in,
  output logic od_ack_out,
  output logic od_abort_out,
  output logic [31:0] od_rdata_out,
  // Retained settings image.
  input wire logic restore_load_in,
  input wire logic [AIS_IMG_W-1:0] restore_image_in,
  output logic [AIS_IMG_W-1:0] save_image_out,
  // Live results.
  output logic signed [AIS_VAL_W-1:0] value_ch1_out,
  output logic signed [AIS_VAL_W-1:0] value_ch2_out,
  output logic busy_out
);

  typedef struct packed {
    ais_state_e st;
    logic [1:0] pend;
    logic [1:0][ADC_W-1:0] raw;
    logic [1:0][AIS_SET_W-1:0] offs;
    logic [1:0][AIS_SET_W-1:0] mul;
    logic [1:0][AIS_SET_W-1:0] dvs;
    logic [1:0][AIS_VAL_W-1:0] val;
    logic cur;
    logic rr;
    logic start;
    logic [AIS_WIDE_W-1:0] num_a;
    logic [AIS_SET_W-1:0] den_b;
    logic ack;
    logic abort;
    logic [31:0] rdata;
  } ais_s;

  ais_s s_q;
  ais_s s_d;

  logic div_done;
  logic div_zero;
  logic signed [AIS_WIDE_W-1:0] div_quot;

  // Sign-extends a 16-bit setting to a 32-bit read word.
  function automatic logic [31:0] sext16(input logic [AIS_SET_W-1:0] v);
    sext16 = {{(32 - AIS_SET_W){v[AIS_SET_W-1]}}, v};
  endfunction

  // Sign-extends a 16-bit setting to the wide datapath.
  function automatic logic signed [AIS_WIDE_W-1:0] wide16(input logic [AIS_SET_W-1:0] v);
    wide16 = {{(AIS_WIDE_W - AIS_SET_W){v[AIS_SET_W-1]}}, v};
  endfunction

  // Returns the channel number addressed by a subindex, or flags it as absent.
  function automatic logic [1:0] chan_of(input logic [7:0] sub);
    if (sub == AIS_SUB_CH1) begin
      chan_of = 2'b10;
    end else if (sub == AIS_SUB_CH2 && HAS_CH2) begin
      chan_of = 2'b11;
    end else begin
      chan_of = 2'b00;
    end
  endfunction

  always_comb begin
    logic [1:0] ch;
    logic signed [AIS_WIDE_W-1:0] raw_w;
    logic signed [AIS_WIDE_W-1:0] sum_w;
    logic signed [2*AIS_WIDE_W-1:0] prod_w;
    logic pick;
    ch = 2'b00;
    raw_w = '0;
    sum_w = '0;
    prod_w = '0;
    pick = 1'b0;
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.abort = 1'b0;
    s_d.start = 1'b0;

    // Settings restored from the retained image; live values are never part of it.
    if (restore_load_in) begin
      for (int c = 0; c < 2; c++) begin
        s_d.offs[c] = restore_image_in[AIS_IMG_OFF_POS + c*AIS_IMG_CH_STRIDE +: AIS_SET_W];
        s_d.mul[c] = restore_image_in[AIS_IMG_MUL_POS + c*AIS_IMG_CH_STRIDE +: AIS_SET_W];
        s_d.dvs[c] = restore_image_in[AIS_IMG_DIV_POS + c*AIS_IMG_CH_STRIDE +: AIS_SET_W];
      end
    end

    // Object dictionary requests are answered in the following cycle.
    if (od_req_in) begin
      s_d.ack = 1'b1;
      s_d.rdata = AIS_RDATA_RST;
      ch = chan_of(od_subidx_in);
      if (od_index_in == AIS_IDX_VALUE || od_index_in == AIS_IDX_OFFSET ||
          od_index_in == AIS_IDX_MUL || od_index_in == AIS_IDX_DIV) begin
        if (od_subidx_in == AIS_SUB_COUNT) begin
          if (od_write_in) begin
            s_d.abort = 1'b1;
          end else begin
            s_d.rdata = {24'h00_0000, AIS_NUM_CH};
          end
        end else if (!ch[1]) begin
          s_d.abort = 1'b1;
        end else if (od_index_in == AIS_IDX_VALUE) begin
          if (od_write_in) begin
            s_d.abort = 1'b1;
          end else begin
            s_d.rdata = s_q.val[ch[0]];
          end
        end else if (od_index_in == AIS_IDX_OFFSET) begin
          if (od_write_in) begin
            s_d.offs[ch[0]] = od_wdata_in[AIS_SET_W-1:0];
          end else begin
            s_d.rdata = sext16(s_q.offs[ch[0]]);
          end
        end else if (od_index_in == AIS_IDX_MUL) begin
          if (od_write_in) begin
            s_d.mul[ch[0]] = od_wdata_in[AIS_SET_W-1:0];
          end else begin
            s_d.rdata = sext16(s_q.mul[ch[0]]);
          end
        end else begin
          if (od_write_in) begin
            s_d.dvs[ch[0]] = od_wdata_in[AIS_SET_W-1:0];
          end else begin
            s_d.rdata = sext16(s_q.dvs[ch[0]]);
          end
        end
      end else begin
        s_d.abort = 1'b1;
      end
    end

    // Sequencer: one channel at a time through offset, multiply and divide.
    case (s_q.st)
      AIS_IDLE: begin
        if (s_q.pend != 2'b00) begin
          pick = (s_q.pend == 2'b11) ? s_q.rr : s_q.pend[1];
          s_d.cur = pick;
          s_d.rr = ~pick;
          s_d.pend[pick] = 1'b0;
          s_d.st = AIS_CALC;
        end
      end
      AIS_CALC: begin
        raw_w = {{(AIS_WIDE_W - ADC_W){1'b0}}, s_q.raw[s_q.cur]};
        sum_w = raw_w + wide16(s_q.offs[s_q.cur]);
        prod_w = sum_w * wide16(s_q.mul[s_q.cur]);
        s_d.num_a = prod_w[AIS_WIDE_W-1:0];
        s_d.den_b = s_q.dvs[s_q.cur];
        s_d.start = 1'b1;
        s_d.st = AIS_WAIT;
      end
      AIS_WAIT: begin
        if (div_done) begin
          if (!div_zero) begin
            s_d.val[s_q.cur] = div_quot[AIS_VAL_W-1:0];
          end
          s_d.st = AIS_IDLE;
        end
      end
      default: begin
        s_d.st = AIS_IDLE;
      end
    endcase

    // A new reading is taken after the sequencer clears its pending flag, so it is never lost.
    // Counts are converter digits; full scale is 10 V or 20 mA over 1023 digits.
    if (raw_valid_ch1_in) begin
      s_d.raw[0] = raw_ch1_in;
      s_d.pend[0] = 1'b1;
    end
    if (raw_valid_ch2_in && HAS_CH2) begin
      s_d.raw[1] = raw_ch2_in;
      s_d.pend[1] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.st <= AIS_IDLE;
      for (int c = 0; c < 2; c++) begin
        s_q.offs[c] <= AIS_OFFSET_RST;
        s_q.mul[c] <= AIS_FACTOR_RST;
        s_q.dvs[c] <= AIS_FACTOR_RST;
        s_q.val[c] <= AIS_VALUE_RST;
      end
      s_q.den_b <= AIS_FACTOR_RST;
      s_q.rdata <= AIS_RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ais_div #(
    .A_W(AIS_WIDE_W),
    .B_W(AIS_SET_W)
  ) u_div (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .start_in(s_q.start),
    .dividend_in(s_q.num_a),
    .divisor_in(s_q.den_b),
    .done_out(div_done),
    .div_zero_out(div_zero),
    .quot_out(div_quot)
  );

  // Settings image for non-volatile storage; it holds only the three settings per channel.
  always_comb begin
    save_image_out = '0;
    for (int c = 0; c < 2; c++) begin
      save_image_out[AIS_IMG_OFF_POS + c*AIS_IMG_CH_STRIDE +: AIS_SET_W] = s_q.offs[c];
      save_image_out[AIS_IMG_MUL_POS + c*AIS_IMG_CH_STRIDE +: AIS_SET_W] = s_q.mul[c];
      save_image_out[AIS_IMG_DIV_POS + c*AIS_IMG_CH_STRIDE +: AIS_SET_W] = s_q.dvs[c];
    end
  end

  assign od_ack_out = s_q.ack;
  assign od_abort_out = s_q.abort;
  assign od_rdata_out = s_q.rdata;
  assign value_ch1_out = s_q.val[0];
  assign value_ch2_out = s_q.val[1];
  assign busy_out = (s_q.st != AIS_IDLE);

endmodule
`default_nettype wire

// ### core/ais_pkg.sv
// Constants, object indices and reset values of the analog input scaling block.
package ais_pkg;

  // Object dictionary indices.
  localparam logic [15:0] AIS_IDX_VALUE = 16'h3320;
  localparam logic [15:0] AIS_IDX_OFFSET = 16'h3321;
  localparam logic [15:0] AIS_IDX_MUL = 16'h3322;
  localparam logic [15:0] AIS_IDX_DIV = 16'h3323;

  // Subindices.
  localparam logic [7:0] AIS_SUB_COUNT = 8'h00;
  localparam logic [7:0] AIS_SUB_CH1 = 8'h01;
  localparam logic [7:0] AIS_SUB_CH2 = 8'h02;

  // Entry count reported at subindex zero.
  localparam logic [7:0] AIS_NUM_CH = 8'h02;

  // Values after reset.
  localparam logic [15:0] AIS_OFFSET_RST = 16'h0000;
  localparam logic [15:0] AIS_FACTOR_RST = 16'h0001;
  localparam logic [31:0] AIS_VALUE_RST = 32'h0000_0000;
  localparam logic [31:0] AIS_RDATA_RST = 32'h0000_0000;

  // Full scale of the converter and the physical ranges it maps onto.
  localparam int AIS_FS_DIGITS = 1023;
  localparam int AIS_FS_VOLTS = 10;
  localparam int AIS_FS_MILLIAMPS = 20;

  // Datapath widths.
  localparam int AIS_SET_W = 16;
  localparam int AIS_WIDE_W = 34;
  localparam int AIS_VAL_W = 32;

  // Layout of the retained settings image.
  localparam int AIS_IMG_W = 96;
  localparam int AIS_IMG_OFF_POS = 0;
  localparam int AIS_IMG_MUL_POS = 32;
  localparam int AIS_IMG_DIV_POS = 64;
  localparam int AIS_IMG_CH_STRIDE = 16;

  // Divider iteration count and its counter width.
  localparam logic [5:0] AIS_DIV_STEPS = 6'd34;

  // Sequencer states.
  typedef enum logic [1:0] {
    AIS_IDLE,
    AIS_CALC,
    AIS_WAIT
  } ais_state_e;

  // Divider states.
  typedef enum logic {
    AIS_DIV_IDLE,
    AIS_DIV_RUN
  } ais_div_state_e;

endpackage

// ### core/ais_div.sv
// Iterative signed divider that truncates its quotient toward zero.
`timescale 1ns/1ps
`default_nettype none
module ais_div import ais_pkg::*; #(
  parameter int A_W = 34,
  parameter int B_W = 16
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Request.
  input wire logic start_in,
  input wire logic signed [A_W-1:0] dividend_in,
  input wire logic signed [B_W-1:0] divisor_in,
  // Answer.
  output logic done_out,
  output logic div_zero_out,
  output logic signed [A_W-1:0] quot_out
);

  typedef struct packed {
    ais_div_state_e st;
    logic [5:0] cnt;
    logic [B_W:0] rem;
    logic [A_W-1:0] quo;
    logic [B_W-1:0] bmag;
    logic neg;
    logic done;
    logic dz;
    logic [A_W-1:0] res;
  } ais_div_s;

  ais_div_s s_q;
  ais_div_s s_d;

  // Magnitude of a signed dividend.
  function automatic logic [A_W-1:0] abs_a(input logic signed [A_W-1:0] v);
    abs_a = v[A_W-1] ? A_W'(-v) : A_W'(v);
  endfunction

  // Magnitude of a signed divisor.
  function automatic logic [B_W-1:0] abs_b(input logic signed [B_W-1:0] v);
    abs_b = v[B_W-1] ? B_W'(-v) : B_W'(v);
  endfunction

  always_comb begin
    logic [B_W:0] rem_sh;
    rem_sh = '0;
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      AIS_DIV_IDLE: begin
        if (start_in) begin
          if (divisor_in == '0) begin
            s_d.done = 1'b1;
            s_d.dz = 1'b1;
          end else begin
            s_d.dz = 1'b0;
            s_d.quo = abs_a(dividend_in);
            s_d.bmag = abs_b(divisor_in);
            s_d.neg = dividend_in[A_W-1] ^ divisor_in[B_W-1];
            s_d.rem = '0;
            s_d.cnt = AIS_DIV_STEPS;
            s_d.st = AIS_DIV_RUN;
          end
        end
      end
      AIS_DIV_RUN: begin
        rem_sh = {s_q.rem[B_W-1:0], s_q.quo[A_W-1]};
        s_d.quo = {s_q.quo[A_W-2:0], 1'b0};
        if (rem_sh >= {1'b0, s_q.bmag}) begin
          s_d.rem = rem_sh - {1'b0, s_q.bmag};
          s_d.quo[0] = 1'b1;
        end else begin
          s_d.rem = rem_sh;
        end
        s_d.cnt = s_q.cnt - 6'd1;
        if (s_q.cnt == 6'd1) begin
          s_d.res = s_q.neg ? A_W'(-s_d.quo) : s_d.quo;
          s_d.done = 1'b1;
          s_d.st = AIS_DIV_IDLE;
        end
      end
      default: begin
        s_d.st = AIS_DIV_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      s_q <= '0;
      s_q.st <= AIS_DIV_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign done_out = s_q.done;
  assign div_zero_out = s_q.dz;
  assign quot_out = s_q.res;

endmodule
`default_nettype wire

// ### dv/ais_monitor.sv
// Port-level checker for the analog input scaling block.
`timescale 1ns/1ps
`default_nettype none
module ais_monitor import ais_pkg::*; (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Watched ports.
  input wire logic raw_valid_ch1_in,
  input wire logic od_req_in,
  input wire logic od_write_in,
  input wire logic [15:0] od_index_in,
  input wire logic [7:0] od_subidx_in,
  input wire logic od_ack_out,
  input wire logic od_abort_out,
  input wire logic [31:0] od_rdata_out,
  input wire logic [AIS_IMG_W-1:0] save_image_out,
  input wire logic signed [AIS_VAL_W-1:0] value_ch1_out,
  input wire logic busy_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  a_ack_next: assert property (od_req_in |=> od_ack_out)
    else $error("request not answered");
  a_ack_cause: assert property (od_ack_out |-> $past(od_req_in))
    else $error("answer without request");
  a_abort_ack: assert property (od_abort_out |-> od_ack_out)
    else $error("refusal without answer");
  a_value_ro: assert property (od_req_in && od_write_in && od_index_in == AIS_IDX_VALUE |=> od_abort_out)
    else $error("value write accepted");
  a_count_val: assert property (od_req_in && !od_write_in && od_subidx_in == AIS_SUB_COUNT
    && od_index_in >= AIS_IDX_VALUE && od_index_in <= AIS_IDX_DIV |=> !od_abort_out
    && od_rdata_out == 32'(AIS_NUM_CH))
    else $error("entry count wrong");
  a_count_ro: assert property (od_req_in && od_write_in && od_subidx_in == AIS_SUB_COUNT |=> od_abort_out)
    else $error("entry count write accepted");
  a_sub_range: assert property (od_req_in && od_subidx_in > AIS_SUB_CH2 |=> od_abort_out)
    else $error("bad subindex accepted");
  a_value_hold: assert property (!busy_out && !$past(busy_out)
    && !$past(busy_out, 2) |-> $stable(value_ch1_out))
    else $error("value moved while idle");
  a_busy_start: assert property (raw_valid_ch1_in && !busy_out |-> ##[1:3] busy_out)
    else $error("sample not started");
  a_busy_len: assert property ($rose(busy_out) |-> ##[3:90] !busy_out)
    else $error("computation too long");
  a_reset_img: assert property ($rose(resetn_in) |->
    save_image_out == 96'h0001_0001_0001_0001_0000_0000 && value_ch1_out == 0 && !busy_out)
    else $error("reset state wrong");
endmodule
bind ais_top ais_monitor u_ais_monitor (.sys_clk_in, .resetn_in, .raw_valid_ch1_in, .od_req_in, .od_write_in,
  .od_index_in, .od_subidx_in, .od_ack_out, .od_abort_out, .od_rdata_out, .save_image_out, .value_ch1_out, .busy_out);
`default_nettype wire

// ### dv/ais_master.sv
// Fieldbus master model issuing object dictionary requests.
`timescale 1ns/1ps
`default_nettype none
module ais_master (
  // Clock.
  input wire logic sys_clk_in,
  // Request.
  output var logic od_req_out,
  output var logic od_write_out,
  output var logic [15:0] od_index_out,
  output var logic [7:0] od_subidx_out,
  output var logic [31:0] od_wdata_out,
  // Answer.
  input wire logic od_ack_in,
  input wire logic od_abort_in,
  input wire logic [31:0] od_rdata_in
);
  initial begin
    od_req_out = 1'b0;
    od_write_out = 1'b0;
    od_index_out = 16'h0000;
    od_subidx_out = 8'h00;
    od_wdata_out = 32'h0000_0000;
  end
  // One-cycle request; the answer is taken at the edge after the request was taken.
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
    output logic ab, output logic [31:0] rd);
    @(posedge sys_clk_in);
    od_req_out <= 1'b1;
    od_write_out <= wr;
    od_index_out <= idx;
    od_subidx_out <= sub;
    od_wdata_out <= wd;
    @(posedge sys_clk_in);
    od_req_out <= 1'b0;
    @(posedge sys_clk_in);
    ab = od_ack_in ? od_abort_in : 1'bx;
    rd = od_ack_in ? od_rdata_in : 'x;
  endtask
endmodule
`default_nettype wire

// ### dv/analog_input_scaling_test.sv
// Self-checking testbench of the analog input scaling block.
`timescale 1ns/1ps
`default_nettype none
module analog_input_scaling_test;
  import ais_pkg::*;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic v1 = 1'b0;
  logic v2 = 1'b0;
  logic [9:0] r1 = 10'h000;
  logic [9:0] r2 = 10'h000;
  logic rl = 1'b0;
  logic [AIS_IMG_W-1:0] img = '0;
  logic req, wr, ack, ab, busy_out;
  logic [15:0] idx;
  logic [7:0] sub;
  logic [31:0] wd, rd;
  logic [AIS_IMG_W-1:0] save_image_out;
  logic signed [31:0] value_ch1_out, value_ch2_out;
  int failures = 0;
  int check_count = 0;
  int t_ch[3] = '{1, 2, 1};
  int t_raw[3] = '{1023, 512, 1000};
  int t_off[3] = '{0, 0, -100};
  int t_mul[3] = '{10, 20, -3};
  int t_div[3] = '{1023, 1023, 7};
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  ais_top u_ais_top (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .raw_valid_ch1_in(v1), .raw_ch1_in(r1),
    .raw_valid_ch2_in(v2), .raw_ch2_in(r2), .od_req_in(req), .od_write_in(wr), .od_index_in(idx),
    .od_subidx_in(sub), .od_wdata_in(wd), .od_ack_out(ack), .od_abort_out(ab), .od_rdata_out(rd),
    .restore_load_in(rl), .restore_image_in(img), .save_image_out(save_image_out),
    .value_ch1_out(value_ch1_out), .value_ch2_out(value_ch2_out), .busy_out(busy_out));
  ais_master u_ais_master (.sys_clk_in(sys_clk_in), .od_req_out(req), .od_write_out(wr), .od_index_out(idx),
    .od_subidx_out(sub), .od_wdata_out(wd), .od_ack_in(ack), .od_abort_in(ab), .od_rdata_in(rd));
  task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
    check_count++;
    if (got !== ex) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Read data is expected in d; a refused request expects abort only.
  task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic ex);
    logic a;
    logic [31:0] r;
    u_ais_master.xfer(w, i, s, d, a, r);
    check_val("od_abort", 32'(ex), 32'(a));
    if (!w && !ex) check_val("od_rdata", d, r);
  endtask
  task automatic sample(input int ch, input logic [9:0] r, input logic [31:0] ex);
    int n;
    @(posedge sys_clk_in);
    v1 <= (ch == 1);
    v2 <= (ch == 2);
    r1 <= r;
    r2 <= r;
    @(posedge sys_clk_in);
    v1 <= 1'b0;
    v2 <= 1'b0;
    n = 0;
    while (busy_out !== 1'b1 && n < 5) begin
      @(posedge sys_clk_in);
      n++;
    end
    while (busy_out !== 1'b0 && n < 95) begin
      @(posedge sys_clk_in);
      n++;
    end
    @(posedge sys_clk_in);
    check_val("value", ex, (ch == 1) ? value_ch1_out : value_ch2_out);
  endtask
  function automatic logic [31:0] scale(input int r, input int o, input int m, input int d);
    return 32'((longint'(r) + o) * m / d);
  endfunction
  task automatic setup(input int ch, input int o, input int m, input int d);
    od(1'b1, AIS_IDX_OFFSET, 8'(ch), 32'(o), 1'b0);
    od(1'b1, AIS_IDX_MUL, 8'(ch), 32'(m), 1'b0);
    od(1'b1, AIS_IDX_DIV, 8'(ch), 32'(d), 1'b0);
    od(1'b0, AIS_IDX_MUL, 8'(ch), 32'(m), 1'b0);
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #40000;
    failures++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      od(1'b0, AIS_IDX_VALUE + 16'(i), AIS_SUB_COUNT, 32'(AIS_NUM_CH), 1'b0);
      for (int s = 1; s < 3; s++) begin
        od(1'b0, AIS_IDX_VALUE + 16'(i), 8'(s), 32'(i > 1), 1'b0);
      end
    end
    od(1'b1, AIS_IDX_VALUE, AIS_SUB_CH1, 32'h0000_0005, 1'b1);
    od(1'b1, AIS_IDX_MUL, AIS_SUB_COUNT, 32'h0000_0005, 1'b1);
    od(1'b0, AIS_IDX_MUL, 8'h03, 32'h0000_0000, 1'b1);
    od(1'b0, 16'h3324, AIS_SUB_CH1, 32'h0000_0000, 1'b1);
    $display("test reset_map done");
    sample(1, 10'h064, 32'h0000_0064);
    sample(2, 10'h3FF, 32'h0000_03FF);
    od(1'b0, AIS_IDX_VALUE, AIS_SUB_CH2, 32'h0000_03FF, 1'b0);
    $display("test defaults done");
    for (int i = 0; i < 3; i++) begin
      setup(t_ch[i], t_off[i], t_mul[i], t_div[i]);
      sample(t_ch[i], 10'(t_raw[i]), scale(t_raw[i], t_off[i], t_mul[i], t_div[i]));
    end
    od(1'b0, AIS_IDX_VALUE, AIS_SUB_CH1, scale(1000, -100, -3, 7), 1'b0);
    check_val("save_lo", 32'h0000_FF9C, save_image_out[31:0]);
    check_val("save_mid", 32'h0014_FFFD, save_image_out[63:32]);
    check_val("save_hi", 32'h03FF_0007, save_image_out[95:64]);
    // A zero divisor leaves the last channel value in place.
    od(1'b1, AIS_IDX_DIV, AIS_SUB_CH2, 32'h0000_0000, 1'b0);
    sample(2, 10'h100, 32'h0000_000A);
    $display("test scaling done");
    @(posedge sys_clk_in);
    img <= 96'h0001_0001_0001_0001_0000_0000;
    rl <= 1'b1;
    @(posedge sys_clk_in);
    rl <= 1'b0;
    od(1'b0, AIS_IDX_DIV, AIS_SUB_CH2, 32'h0000_0001, 1'b0);
    sample(1, 10'h064, 32'h0000_0064);
    $display("test restore done");
    finish_test();
  end
endmodule
`default_nettype wire
